//--- pkg/hsa_pkg.sv
// Shared constants and types for the host slave and arbitration link.
package hsa_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam int SIZE_W = 2;
  // Mandatory read wait states before data is driven.
  localparam logic [1:0] READ_WAIT = 2'h2;
  // Cycles between fetch indicator and bus request, and grant release to fetch release.
  localparam logic [1:0] FETCH_LEAD = 2'h1;
  // Cycles the aborted tenure holds the bus before release.
  localparam logic [1:0] ABORT_HOLD = 2'h1;
  // Slave wait states the host end allows before it gives up on an acknowledge.
  localparam logic [3:0] HOST_TIMEOUT = 4'hF;
  localparam logic [ADDR_W-1:0] REG_MASK = 7'h7F;
  typedef enum logic [2:0] {
    HSA_S_IDLE, HSA_S_WAIT, HSA_S_ACK, HSA_S_DONE
  } hsa_slv_t;
  typedef enum logic [2:0] {
    HSA_A_IDLE, HSA_A_FETCH, HSA_A_REQ, HSA_A_OWN, HSA_A_ABORT, HSA_A_TAIL
  } hsa_arb_t;
  typedef enum logic [1:0] {
    HSA_H_IDLE, HSA_H_STROBE, HSA_H_TERM
  } hsa_hst_t;
endpackage

//--- pkg/hsa_if.sv
// Host bus wires between the adapter end and the host end.
`timescale 1ns/100ps
interface hsa_if;
  logic address_strobe_n;
  logic rd_wr_n;
  logic [hsa_pkg::ADDR_W-1:0] addr;
  logic [hsa_pkg::SIZE_W-1:0] transfer_size;
  logic chip_select_n;
  logic [hsa_pkg::DATA_W-1:0] host_data;
  logic host_data_oe_n;
  logic [hsa_pkg::DATA_W-1:0] dev_data;
  logic dev_data_oe_n;
  logic burst_ack_n;
  logic slave_ack_n;
  logic bus_error_n;
  logic sync_termination_n;
  logic bus_request_n;
  logic bus_grant_n;
  logic grant_ack_in_n;
  logic grant_acknowledge_n;
  logic grant_ack_oe_n;
  logic master_n;
  logic fetch_n;
  logic snoop_ctrl_0;
  logic transfer_start_n;
  modport dev (
    input address_strobe_n, rd_wr_n, addr, transfer_size, chip_select_n, host_data, host_data_oe_n,
    input sync_termination_n, bus_grant_n, grant_ack_in_n, snoop_ctrl_0,
    output dev_data, dev_data_oe_n, burst_ack_n, slave_ack_n, bus_error_n, bus_request_n,
    output grant_acknowledge_n, grant_ack_oe_n, master_n, fetch_n, transfer_start_n
  );
  modport host (
    output address_strobe_n, rd_wr_n, addr, transfer_size, chip_select_n, host_data, host_data_oe_n,
    output sync_termination_n, bus_grant_n, grant_ack_in_n, snoop_ctrl_0,
    input dev_data, dev_data_oe_n, burst_ack_n, slave_ack_n, bus_error_n, bus_request_n,
    input grant_acknowledge_n, grant_ack_oe_n, master_n, fetch_n, transfer_start_n
  );
endinterface

//--- src/hsa_dev.sv
// Adapter end: slave register cycles and bus mastership arbitration.
`timescale 1ns/100ps
// Operation
// - CPU sets direction, address, size before strobe.
// - Chip select qualified on later rising edge.
// - Burst acknowledge held off during slave cycles.
// - Exactly two wait states before read data.
// - End cycle with acknowledge or bus error.
// - Host terminates every strobe synchronously.
// - Strobe removal releases acknowledge and data.
// - CPU holds write data until acknowledged.
// - Fetch indicator first, then bus request.
// - Wait grant and free acknowledge, then own.
// - Prior owner releases strobe and termination.
// - Fast arbitration acknowledges grant immediately.
// - Interrupt during request aborts after handshake.
// - Snoop mode requests bus after snoop rise.
// - Request follows fetch by one clock.
// - Fetch released one clock after acknowledge.
// - Fetch held through retried operation.
module hsa_dev (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  hsa_if.dev bus,
  input wire logic fast_arb_i,
  input wire logic snoop_mode_i,
  input wire logic master_req_i,
  input wire logic fetch_req_i,
  input wire logic retry_i,
  input wire logic scsi_irq_i,
  input wire logic tenure_done_i,
  input wire logic reg_error_i,
  input wire logic [hsa_pkg::DATA_W-1:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic [hsa_pkg::ADDR_W-1:0] reg_addr_o,
  output logic [hsa_pkg::DATA_W-1:0] reg_wdata_o,
  output logic granted_o,
  output logic irq_o
);
  typedef struct packed {
    hsa_pkg::hsa_slv_t slv;
    hsa_pkg::hsa_arb_t arb;
    logic [1:0] wait_cnt;
    logic [1:0] arb_cnt;
    logic is_err;
    logic burst_ack_n;
    logic slave_ack_n;
    logic bus_error_n;
    logic [hsa_pkg::DATA_W-1:0] rdata;
    logic data_oe_n;
    logic reg_wr;
    logic [hsa_pkg::ADDR_W-1:0] reg_addr;
    logic [hsa_pkg::DATA_W-1:0] wdata;
    logic bus_request_n;
    logic grant_ack_n;
    logic grant_oe_n;
    logic master_n;
    logic fetch_n;
    logic snoop_q;
    logic irq;
  } hsa_dev_t;

  hsa_dev_t st_q;
  hsa_dev_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.reg_wr = 1'b0;
    st_d.irq = 1'b0;
    st_d.snoop_q = bus.snoop_ctrl_0;
    unique case (st_q.slv)
      hsa_pkg::HSA_S_IDLE: begin
        if (!bus.address_strobe_n && !bus.chip_select_n) begin
          st_d.slv = hsa_pkg::HSA_S_WAIT;
          st_d.wait_cnt = 2'h0;
          st_d.reg_addr = bus.addr & hsa_pkg::REG_MASK;
          st_d.burst_ack_n = 1'b1;
        end
      end
      hsa_pkg::HSA_S_WAIT: begin
        st_d.wait_cnt = st_q.wait_cnt + 2'h1;
        if (!bus.rd_wr_n || st_q.wait_cnt + 2'h1 == hsa_pkg::READ_WAIT) begin
          st_d.slv = hsa_pkg::HSA_S_ACK;
          st_d.is_err = reg_error_i;
          if (bus.rd_wr_n && !reg_error_i) begin
            st_d.rdata = reg_rdata_i;
            st_d.data_oe_n = 1'b0;
          end
        end
      end
      hsa_pkg::HSA_S_ACK: begin
        st_d.slave_ack_n = st_q.is_err;
        st_d.bus_error_n = !st_q.is_err;
        if (!bus.rd_wr_n && !st_q.is_err) begin
          st_d.reg_wr = 1'b1;
          st_d.wdata = bus.host_data;
        end
        st_d.slv = hsa_pkg::HSA_S_DONE;
      end
      hsa_pkg::HSA_S_DONE: begin
        if (bus.address_strobe_n) begin
          st_d.slave_ack_n = 1'b1;
          st_d.bus_error_n = 1'b1;
          st_d.data_oe_n = 1'b1;
          st_d.burst_ack_n = 1'b0;
          st_d.slv = hsa_pkg::HSA_S_IDLE;
        end
      end
      default: st_d.slv = hsa_pkg::HSA_S_IDLE;
    endcase

    unique case (st_q.arb)
      hsa_pkg::HSA_A_IDLE: begin
        if (master_req_i || (snoop_mode_i && bus.snoop_ctrl_0 && !st_q.snoop_q)) begin
          st_d.fetch_n = !fetch_req_i;
          st_d.arb_cnt = 2'h0;
          st_d.arb = fetch_req_i ? hsa_pkg::HSA_A_FETCH : hsa_pkg::HSA_A_REQ;
          if (!fetch_req_i) begin
            st_d.bus_request_n = 1'b0;
          end
        end
      end
      hsa_pkg::HSA_A_FETCH: begin
        st_d.bus_request_n = 1'b0;
        st_d.arb = hsa_pkg::HSA_A_REQ;
      end
      hsa_pkg::HSA_A_REQ: begin
        if (!bus.bus_grant_n && (fast_arb_i ||
            (bus.grant_ack_in_n && bus.address_strobe_n && bus.sync_termination_n))) begin
          st_d.grant_ack_n = 1'b0;
          st_d.grant_oe_n = 1'b0;
          st_d.master_n = 1'b0;
          st_d.bus_request_n = 1'b1;
          st_d.arb = scsi_irq_i ? hsa_pkg::HSA_A_ABORT : hsa_pkg::HSA_A_OWN;
          st_d.arb_cnt = 2'h0;
        end
      end
      hsa_pkg::HSA_A_OWN: begin
        if (tenure_done_i && !retry_i) begin
          st_d.grant_ack_n = 1'b1;
          st_d.master_n = 1'b1;
          st_d.arb = hsa_pkg::HSA_A_TAIL;
        end
      end
      hsa_pkg::HSA_A_ABORT: begin
        st_d.arb_cnt = st_q.arb_cnt + 2'h1;
        if (st_q.arb_cnt + 2'h1 == hsa_pkg::ABORT_HOLD) begin
          st_d.grant_ack_n = 1'b1;
          st_d.master_n = 1'b1;
          st_d.irq = 1'b1;
          st_d.arb = hsa_pkg::HSA_A_TAIL;
        end
      end
      hsa_pkg::HSA_A_TAIL: begin
        st_d.grant_oe_n = 1'b1;
        st_d.fetch_n = 1'b1;
        st_d.arb = hsa_pkg::HSA_A_IDLE;
      end
      default: st_d.arb = hsa_pkg::HSA_A_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
      st_q.slv <= hsa_pkg::HSA_S_IDLE;
      st_q.arb <= hsa_pkg::HSA_A_IDLE;
      st_q.slave_ack_n <= 1'b1;
      st_q.bus_error_n <= 1'b1;
      st_q.data_oe_n <= 1'b1;
      st_q.bus_request_n <= 1'b1;
      st_q.grant_ack_n <= 1'b1;
      st_q.grant_oe_n <= 1'b1;
      st_q.master_n <= 1'b1;
      st_q.fetch_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.dev_data = st_q.rdata;
  assign bus.dev_data_oe_n = st_q.data_oe_n;
  assign bus.burst_ack_n = st_q.burst_ack_n;
  assign bus.slave_ack_n = st_q.slave_ack_n;
  assign bus.bus_error_n = st_q.bus_error_n;
  assign bus.bus_request_n = st_q.bus_request_n;
  assign bus.grant_acknowledge_n = st_q.grant_ack_n;
  assign bus.grant_ack_oe_n = st_q.grant_oe_n;
  assign bus.master_n = st_q.master_n;
  assign bus.fetch_n = st_q.fetch_n;
  // An aborted tenure never starts a transfer; cycles are outside this block.
  assign bus.transfer_start_n = 1'b1;
  assign reg_wr_o = st_q.reg_wr;
  assign reg_addr_o = st_q.reg_addr;
  assign reg_wdata_o = st_q.wdata;
  assign granted_o = (st_q.arb == hsa_pkg::HSA_A_OWN);
  assign irq_o = st_q.irq;
endmodule

//--- src/hsa_host.sv
// Host end: CPU slave accesses with termination, and bus arbiter.
`timescale 1ns/100ps
module hsa_host (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  hsa_if.host bus,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_sel_i,
  input wire logic [hsa_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [hsa_pkg::SIZE_W-1:0] req_size_i,
  input wire logic [hsa_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic snoop_i,
  input wire logic grant_enable_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic rsp_error_o,
  output logic [hsa_pkg::DATA_W-1:0] rsp_rdata_o
);
  typedef struct packed {
    hsa_pkg::hsa_hst_t st;
    logic strobe_n;
    logic rd_wr_n;
    logic [hsa_pkg::ADDR_W-1:0] addr;
    logic [hsa_pkg::SIZE_W-1:0] size;
    logic cs_n;
    logic sel;
    logic [hsa_pkg::DATA_W-1:0] wdata;
    logic wdata_oe_n;
    logic sync_termination_n_n;
    logic [3:0] tmo;
    logic grant_n;
    logic snoop;
    logic rsp_valid;
    logic rsp_error;
    logic [hsa_pkg::DATA_W-1:0] rdata;
  } hsa_host_t;

  hsa_host_t st_q;
  hsa_host_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.rsp_valid = 1'b0;
    st_d.snoop = snoop_i;
    // Grant follows request only while no slave access is pending, so strobe and termination stay idle.
    // bus idle at grant
    st_d.grant_n = !(grant_enable_i && !bus.bus_request_n && !req_valid_i && st_q.st == hsa_pkg::HSA_H_IDLE);
    unique case (st_q.st)
      hsa_pkg::HSA_H_IDLE: begin
        if (req_valid_i && bus.master_n && st_q.grant_n) begin
          st_d.rd_wr_n = !req_write_i;
          st_d.addr = req_addr_i;
          st_d.size = req_size_i;
          st_d.wdata = req_wdata_i;
          st_d.sel = req_sel_i;
          st_d.st = hsa_pkg::HSA_H_STROBE;
          st_d.tmo = 4'h0;
        end
      end
      hsa_pkg::HSA_H_STROBE: begin
        st_d.strobe_n = 1'b0;
        st_d.cs_n = !st_q.sel;
        st_d.wdata_oe_n = st_q.rd_wr_n;
        if (!st_q.strobe_n) begin
          st_d.tmo = st_q.tmo + 4'h1;
          if (!bus.slave_ack_n || !bus.bus_error_n || st_q.tmo == hsa_pkg::HOST_TIMEOUT || !st_q.sel) begin
            st_d.sync_termination_n_n = 1'b0;
            st_d.rsp_error = !bus.bus_error_n || (st_q.sel && bus.slave_ack_n);
            st_d.rdata = bus.dev_data;
            st_d.st = hsa_pkg::HSA_H_TERM;
          end
        end
      end
      hsa_pkg::HSA_H_TERM: begin
        st_d.strobe_n = 1'b1;
        st_d.cs_n = 1'b1;
        st_d.sync_termination_n_n = 1'b1;
        st_d.wdata_oe_n = 1'b1;
        st_d.rsp_valid = 1'b1;
        st_d.st = hsa_pkg::HSA_H_IDLE;
      end
      default: st_d.st = hsa_pkg::HSA_H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
      st_q.st <= hsa_pkg::HSA_H_IDLE;
      st_q.strobe_n <= 1'b1;
      st_q.rd_wr_n <= 1'b1;
      st_q.cs_n <= 1'b1;
      st_q.wdata_oe_n <= 1'b1;
      st_q.sync_termination_n_n <= 1'b1;
      st_q.grant_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.address_strobe_n = st_q.strobe_n;
  assign bus.rd_wr_n = st_q.rd_wr_n;
  assign bus.addr = st_q.addr;
  assign bus.transfer_size = st_q.size;
  assign bus.chip_select_n = st_q.cs_n;
  assign bus.host_data = st_q.wdata;
  assign bus.host_data_oe_n = st_q.wdata_oe_n;
  assign bus.sync_termination_n = st_q.sync_termination_n_n;
  assign bus.bus_grant_n = st_q.grant_n;
  // The shared acknowledge wire idles high when the adapter floats it.
  assign bus.grant_ack_in_n = bus.grant_ack_oe_n | bus.grant_acknowledge_n;
  assign bus.snoop_ctrl_0 = st_q.snoop;
  assign req_ready_o = (st_q.st == hsa_pkg::HSA_H_IDLE) && bus.master_n && st_q.grant_n;
  assign rsp_valid_o = st_q.rsp_valid;
  assign rsp_error_o = st_q.rsp_error;
  assign rsp_rdata_o = st_q.rdata;
endmodule

//--- verif/hsa_properties.sv
// Checker for the host bus handshakes between the two ends.
`timescale 1ns/100ps
module hsa_properties (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic address_strobe_n,
  input wire logic rd_wr_n,
  input wire logic chip_select_n,
  input wire logic dev_data_oe_n,
  input wire logic burst_ack_n,
  input wire logic slave_ack_n,
  input wire logic bus_error_n,
  input wire logic sync_termination_n,
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic grant_ack_in_n,
  input wire logic grant_acknowledge_n,
  input wire logic master_n,
  input wire logic fetch_n
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_burst_held_off: assert property ((!slave_ack_n || !bus_error_n) |-> burst_ack_n)
    else $error("burst ack low during a slave answer");
  a_read_wait_two: assert property ($fell(address_strobe_n) && !chip_select_n && rd_wr_n
    |-> dev_data_oe_n [*3] ##[1:2] (!dev_data_oe_n || !bus_error_n)) else $error("read data wait states wrong");
  a_one_answer: assert property ($fell(slave_ack_n) || $fell(bus_error_n)
    |-> !address_strobe_n && (slave_ack_n || bus_error_n)) else $error("bad slave cycle ending");
  a_strobe_release: assert property ($rose(address_strobe_n)
    |-> ##[1:2] (slave_ack_n && bus_error_n && dev_data_oe_n)) else $error("answer not released");
  a_unselected_quiet: assert property (!address_strobe_n && chip_select_n && $past(chip_select_n)
    |-> slave_ack_n && bus_error_n) else $error("answered without chip select");
  a_fetch_first: assert property ($fell(bus_request_n) && !fetch_n |-> !$past(fetch_n))
    else $error("fetch indicator came with request");
  a_request_after_fetch: assert property ($fell(fetch_n) |-> ##[1:2] !bus_request_n)
    else $error("request late after fetch");
  a_grant_taken: assert property (!bus_request_n && !bus_grant_n && grant_ack_in_n && address_strobe_n
    && sync_termination_n |=> !grant_acknowledge_n && !master_n && bus_request_n) else $error("grant not taken");
  a_master_pair: assert property (master_n == grant_acknowledge_n)
    else $error("master and grant ack apart");
  a_fetch_release: assert property ($rose(grant_acknowledge_n) && !fetch_n |-> ##[1:2] fetch_n)
    else $error("fetch held after tenure");
endmodule

//--- verif/testbench.sv
// Self-checking bench joining the adapter end and the host end.
`timescale 1ns/100ps
module testbench;
  logic sys_clk_i, rst_n_i, fast_arb_i, snoop_mode_i, master_req_i, fetch_req_i, retry_i;
  logic scsi_irq_i, tenure_done_i, reg_error_i, reg_wr_o, granted_o, irq_o;
  logic [hsa_pkg::DATA_W-1:0] reg_rdata_i, reg_wdata_o, req_wdata_i, rsp_rdata_o, wr_d;
  logic [hsa_pkg::ADDR_W-1:0] reg_addr_o, req_addr_i, wr_a;
  logic [hsa_pkg::SIZE_W-1:0] req_size_i;
  logic req_valid_i, req_write_i, req_sel_i, snoop_i, grant_enable_i, req_ready_o, rsp_valid_o, rsp_error_o;
  int errors, n_checks, cyc, wr_n, irq_n, ts_n, own_n;
  hsa_if bus();
  hsa_dev hsa_dev_inst (.sys_clk_i, .rst_n_i, .bus(bus.dev), .fast_arb_i, .snoop_mode_i, .master_req_i,
    .fetch_req_i, .retry_i, .scsi_irq_i, .tenure_done_i, .reg_error_i, .reg_rdata_i, .reg_wr_o,
    .reg_addr_o, .reg_wdata_o, .granted_o, .irq_o);
  hsa_host hsa_host_inst (.sys_clk_i, .rst_n_i, .bus(bus.host), .req_valid_i, .req_write_i, .req_sel_i,
    .req_addr_i, .req_size_i, .req_wdata_i, .snoop_i, .grant_enable_i, .req_ready_o, .rsp_valid_o,
    .rsp_error_o, .rsp_rdata_o);
  hsa_properties hsa_properties_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .address_strobe_n(bus.address_strobe_n), .rd_wr_n(bus.rd_wr_n), .chip_select_n(bus.chip_select_n),
    .dev_data_oe_n(bus.dev_data_oe_n), .burst_ack_n(bus.burst_ack_n), .slave_ack_n(bus.slave_ack_n),
    .bus_error_n(bus.bus_error_n), .sync_termination_n(bus.sync_termination_n),
    .bus_request_n(bus.bus_request_n), .bus_grant_n(bus.bus_grant_n), .grant_ack_in_n(bus.grant_ack_in_n),
    .grant_acknowledge_n(bus.grant_acknowledge_n), .master_n(bus.master_n), .fetch_n(bus.fetch_n));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(negedge sys_clk_i) begin
    cyc++;
    if (reg_wr_o === 1'b1) begin
      wr_n++;
      wr_a = reg_addr_o;
      wr_d = reg_wdata_o;
    end
    if (irq_o === 1'b1) irq_n++;
    if (bus.transfer_start_n !== 1'b1) ts_n++;
    if (bus.grant_acknowledge_n === 1'b0) own_n++;
    if (cyc == 4000) begin
      errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic access(input logic wr, input logic sel, input logic [6:0] a, input logic [31:0] d);
    @(negedge sys_clk_i);
    {req_valid_i, req_write_i, req_sel_i, req_addr_i, req_wdata_i} = {1'b1, wr, sel, a, d};
    #1 wait (req_ready_o === 1'b1);
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    wait (rsp_valid_o === 1'b1);
    @(negedge sys_clk_i);
  endtask
  task automatic t_slave();
    int w;
    w = wr_n;
    access(1'b1, 1'b1, 7'h15, 32'hA5C30F96);
    chk(rsp_error_o === 1'b0 && wr_n == w + 1, "write not acknowledged");
    chk(wr_a === 7'h15 && wr_d === 32'hA5C30F96, "write data lost");
    reg_rdata_i = 32'h3C5A96E1;
    access(1'b0, 1'b1, 7'h7F, 32'h00000000);
    chk(rsp_rdata_o === 32'h3C5A96E1 && rsp_error_o === 1'b0, "read data wrong");
    reg_error_i = 1'b1;
    for (int i = 0; i < 2; i++) begin
      access(i[0], 1'b1, 7'h01, 32'h0000FFFF);
      chk(rsp_error_o === 1'b1, "bus error not returned");
    end
    reg_error_i = 1'b0;
    w = wr_n;
    access(1'b1, 1'b0, 7'h15, 32'h12345678);
    chk(wr_n == w && rsp_error_o === 1'b0, "unselected cycle answered");
    $display("slave test done");
  endtask
  task automatic t_tenure(input logic f, input logic fe, input logic r);
    {fast_arb_i, fetch_req_i, retry_i, master_req_i, grant_enable_i} = {f, fe, r, 1'b1, 1'b0};
    repeat (6) @(negedge sys_clk_i);
    chk(bus.master_n === 1'b1 && bus.bus_request_n === 1'b0, "bus taken without grant");
    grant_enable_i = 1'b1;
    wait (granted_o === 1'b1);
    @(negedge sys_clk_i);
    master_req_i = 1'b0;
    chk(bus.master_n === 1'b0 && bus.bus_request_n === 1'b1 && bus.fetch_n === !fe, "no ownership");
    for (int i = 0; i <= r; i++) begin
      tenure_done_i = 1'b1;
      @(negedge sys_clk_i);
      tenure_done_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      chk(bus.fetch_n === (r && i == 0 ? !fe : 1'b1), "fetch hold wrong");
      retry_i = 1'b0;
    end
    chk(bus.master_n === 1'b1 && bus.grant_ack_oe_n === 1'b1, "bus not released");
    $display("tenure test done");
  endtask
  task automatic t_abort();
    int i0, o0;
    {i0, o0, scsi_irq_i, master_req_i} = {irq_n, own_n, 2'b11};
    wait (irq_n > i0);
    {scsi_irq_i, master_req_i} = 2'b00;
    @(negedge sys_clk_i);
    chk(own_n > o0 && ts_n == 0, "abort handshake wrong");
    chk(bus.master_n === 1'b1 && bus.bus_request_n === 1'b1, "abort kept bus");
    $display("abort test done");
  endtask
  task automatic t_snoop();
    int k;
    {snoop_mode_i, grant_enable_i} = 2'b10;
    k = 0;
    @(negedge sys_clk_i);
    snoop_i = 1'b1;
    wait (bus.snoop_ctrl_0 === 1'b1);
    do begin
      @(posedge sys_clk_i);
      #1 k++;
    end while (bus.bus_request_n !== 1'b0 && k < 5);
    chk(k >= 1 && k <= 2, "snoop request timing");
    @(negedge sys_clk_i);
    {snoop_i, snoop_mode_i, grant_enable_i} = 3'b001;
    wait (granted_o === 1'b1);
    @(negedge sys_clk_i);
    tenure_done_i = 1'b1;
    @(negedge sys_clk_i);
    tenure_done_i = 1'b0;
    $display("snoop test done");
  endtask
  initial begin
    {rst_n_i, fast_arb_i, snoop_mode_i, master_req_i, fetch_req_i, retry_i, scsi_irq_i} = 7'h00;
    {tenure_done_i, reg_error_i, reg_rdata_i, req_valid_i, req_write_i, req_sel_i} = '0;
    {req_addr_i, req_size_i, req_wdata_i, snoop_i, grant_enable_i} = '0;
    {errors, n_checks, cyc, wr_n, irq_n, ts_n, own_n} = '0;
    repeat (16) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    @(negedge sys_clk_i);
    t_slave();
    for (int i = 0; i < 8; i++) t_tenure(i[0], i[1], i[2]);
    t_abort();
    t_snoop();
    results();
  end
endmodule
